/* File: sam_defs.svh */
// address mapper constants: field widths, base widths, reset values
// assumes inclusion by the mapper package and modules only
`ifndef SAM_DEFS_SVH
`define SAM_DEFS_SVH
`define SAM_ADDR_W 28
`define SAM_ROW_W 13
`define SAM_COL_W 11
`define SAM_BANK_W 2
`define SAM_OFS32_W 2
`define SAM_OFS16_W 1
`define SAM_COL_BASE8 4'd8
`define SAM_ROW_BASE11 4'd11
`define SAM_RST_ROW 13'h0000
`define SAM_RST_COL 11'h000
`define SAM_RST_BANK 2'h0
`define SAM_RST_OFS 2'h0
`endif

/* File: sam_pkg.sv */
// types shared by the sdram address mapper
// assumes sam_defs.svh sits beside it
`include "sam_defs.svh"
package sam_pkg;
    typedef enum logic [1:0] {
        SAM_BUS16 = 2'b01,
        SAM_BUS32 = 2'b10
    } sam_width_t;
    typedef enum logic [1:0] {
        SAM_ROWS2K = 2'b00,
        SAM_ROWS4K = 2'b01,
        SAM_ROWS8K = 2'b10
    } sam_rows_t;
    typedef enum logic [1:0] {
        SAM_COLS256 = 2'b00,
        SAM_COLS512 = 2'b01,
        SAM_COLS1K = 2'b10,
        SAM_COLS2K = 2'b11
    } sam_cols_t;
    typedef struct packed {
        sam_width_t width;
        sam_rows_t rows;
        sam_cols_t cols;
    } sam_cfg_t;
    typedef struct packed {
        logic [`SAM_BANK_W-1:0] bank_field;
        logic [`SAM_ROW_W-1:0] row;
        logic [`SAM_COL_W-1:0] col;
        logic [`SAM_OFS32_W-1:0] byte_ofs;
    } sam_map_t;
endpackage

/* File: sam_field.sv */
// extracts one right-aligned field of the cpu address under a width mask
// assumes lsb and width stay inside the address
`timescale 1ns/1ps
`include "sam_defs.svh"
module sam_field #(
    parameter int OUT_W = 13
) (
    input wire logic [`SAM_ADDR_W-1:0] addr,
    input wire logic [4:0] lsb,
    input wire logic [3:0] width,
    output logic [OUT_W-1:0] field
);
    logic [`SAM_ADDR_W-1:0] shifted;
    // shift down, then keep only width bits
    assign shifted = addr >> lsb;
    genvar gi;
    generate
        for (gi = 0; gi < OUT_W; gi++) begin : g_bit
            assign field[gi] = shifted[gi] & (4'(gi) < width);
        end
    endgenerate
endmodule

/* File: sam_mapper.sv */
// sdram address mapper: splits a 28-bit cpu byte address into
// byte offset, column, row and bank select, registered one cycle
// assumes config is stable while requests are presented
// Behaviour
// - 32-bit bus: address bits 1:0 are byte offset, column starts bit 2.
// - 16-bit bus: address bit 0 is byte offset, column starts bit 1.
// - two bank bits sit directly above row; upper drives ba1, lower ba0.
// - 2K rows give an 11-bit row directly above the column.
// - 4K rows give a 12-bit row directly above the column.
// - 8K rows give a 13-bit row directly above the column.
// - column width is 8, 9, 10 or 11 bits for 256 to 2048 columns.
// - decode a 28-bit byte address; fields shift up as widths grow.
// - support all row and column counts with byte, half and word access.
`timescale 1ns/1ps
`include "sam_defs.svh"
module sam_mapper
    import sam_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire sam_cfg_t cfg,
    input wire logic req_valid,
    input wire logic [`SAM_ADDR_W-1:0] cpu_addr,
    output logic map_valid_ff,
    output sam_map_t map_ff,
    output logic [1:0] ba_ff,
    output logic halfword_byte_offset_ff
);
    logic [3:0] ofs_w;
    logic [3:0] col_w;
    logic [3:0] row_w;
    logic [4:0] col_lsb;
    logic [4:0] row_lsb;
    logic [4:0] bank_lsb;
    logic [`SAM_COL_W-1:0] col_val;
    logic [`SAM_ROW_W-1:0] row_val;
    logic [`SAM_BANK_W-1:0] bank_val;
    logic [`SAM_OFS32_W-1:0] ofs_val;
    sam_map_t nxt_map;

    // field widths from the configured geometry
    always_comb begin
        case (cfg.width)
            SAM_BUS16: ofs_w = 4'(`SAM_OFS16_W);
            SAM_BUS32: ofs_w = 4'(`SAM_OFS32_W);
            default: ofs_w = 4'(`SAM_OFS32_W);
        endcase
        col_w = `SAM_COL_BASE8 + {2'b00, cfg.cols};
        case (cfg.rows)
            SAM_ROWS2K: row_w = `SAM_ROW_BASE11;
            SAM_ROWS4K: row_w = `SAM_ROW_BASE11 + 4'd1;
            SAM_ROWS8K: row_w = `SAM_ROW_BASE11 + 4'd2;
            default: row_w = `SAM_ROW_BASE11;
        endcase
    end

    assign col_lsb = {1'b0, ofs_w};
    assign row_lsb = col_lsb + {1'b0, col_w};
    assign bank_lsb = row_lsb + {1'b0, row_w};

    // field extraction; bits above bank never enter
    sam_field #(.OUT_W(`SAM_COL_W)) u_col (
        .addr(cpu_addr),
        .lsb(col_lsb),
        .width(col_w),
        .field(col_val)
    );
    sam_field #(.OUT_W(`SAM_ROW_W)) u_row (
        .addr(cpu_addr),
        .lsb(row_lsb),
        .width(row_w),
        .field(row_val)
    );
    sam_field #(.OUT_W(`SAM_BANK_W)) u_bank (
        .addr(cpu_addr),
        .lsb(bank_lsb),
        .width(4'(`SAM_BANK_W)),
        .field(bank_val)
    );
    sam_field #(.OUT_W(`SAM_OFS32_W)) u_ofs (
        .addr(cpu_addr),
        .lsb(5'h00),
        .width(ofs_w),
        .field(ofs_val)
    );

    assign nxt_map = '{bank_field: bank_val, row: row_val, col: col_val, byte_ofs: ofs_val};

    // registered mapping for every access size
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            map_ff <= '{bank_field: `SAM_RST_BANK, row: `SAM_RST_ROW,
                        col: `SAM_RST_COL, byte_ofs: `SAM_RST_OFS};
        end else if (req_valid) begin
            map_ff <= nxt_map;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ba_ff <= `SAM_RST_BANK;
        end else if (req_valid) begin
            ba_ff <= {bank_val[1], bank_val[0]};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            halfword_byte_offset_ff <= 1'b0;
        end else if (req_valid) begin
            halfword_byte_offset_ff <= cpu_addr[0] & (cfg.width == SAM_BUS16);
        end
    end

    // result valid one cycle after request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            map_valid_ff <= 1'b0;
        end else begin
            map_valid_ff <= req_valid;
        end
    end

    // checks against the raw address one cycle earlier, except p_ba (ba_ff against map_ff.bank_field), p_top_ignored (map_ff held) and p_valid/p_idle (req_valid)
    property p_ofs32;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && cfg.width == SAM_BUS32) |=> map_ff.byte_ofs == $past(cpu_addr[1:0]);
    endproperty
    a_ofs32: assert property (p_ofs32) else $error("word byte offset wrong");

    property p_col32_base;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && cfg.width == SAM_BUS32 && cfg.cols == SAM_COLS256)
            |=> map_ff.col == {3'b000, $past(cpu_addr[9:2])};
    endproperty
    a_col32_base: assert property (p_col32_base) else $error("word column misplaced");

    property p_ofs16;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && cfg.width == SAM_BUS16)
            |=> halfword_byte_offset_ff == $past(cpu_addr[0]) && map_ff.byte_ofs[1] == 1'b0;
    endproperty
    a_ofs16: assert property (p_ofs16) else $error("half-word offset wrong");

    property p_col16;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && cfg.width == SAM_BUS16 && cfg.cols == SAM_COLS2K)
            |=> map_ff.col == $past(cpu_addr[11:1]);
    endproperty
    a_col16: assert property (p_col16) else $error("half-word column misplaced");

    property p_ba;
        @(posedge mclk) disable iff (!rst_n)
        map_valid_ff |-> ba_ff == map_ff.bank_field;
    endproperty
    a_ba: assert property (p_ba) else $error("bank lines differ from bank field");

    property p_ba8k;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && cfg.width == SAM_BUS16 && cfg.rows == SAM_ROWS8K && cfg.cols == SAM_COLS2K)
            |=> ba_ff == $past(cpu_addr[26:25]);
    endproperty
    a_ba8k: assert property (p_ba8k) else $error("bank lines misplaced");

    property p_row2k;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && cfg.width == SAM_BUS32 && cfg.rows == SAM_ROWS2K && cfg.cols == SAM_COLS256)
            |=> map_ff.row == {2'b00, $past(cpu_addr[20:10])}
                && map_ff.bank_field == $past(cpu_addr[22:21]);
    endproperty
    a_row2k: assert property (p_row2k) else $error("2k row or bank misplaced");

    property p_row2k16;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && cfg.width == SAM_BUS16 && cfg.rows == SAM_ROWS2K && cfg.cols == SAM_COLS2K)
            |=> map_ff.row == {2'b00, $past(cpu_addr[22:12])}
                && map_ff.bank_field == $past(cpu_addr[24:23]);
    endproperty
    a_row2k16: assert property (p_row2k16) else $error("half-word 2k row or bank misplaced");

    property p_row4k;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && cfg.width == SAM_BUS16 && cfg.rows == SAM_ROWS4K && cfg.cols == SAM_COLS512)
            |=> map_ff.row == {1'b0, $past(cpu_addr[21:10])}
                && map_ff.bank_field == $past(cpu_addr[23:22]);
    endproperty
    a_row4k: assert property (p_row4k) else $error("4k row or bank misplaced");

    property p_row8k;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && cfg.width == SAM_BUS32 && cfg.rows == SAM_ROWS8K && cfg.cols == SAM_COLS2K)
            |=> map_ff.row == $past(cpu_addr[25:13]) && map_ff.bank_field == $past(cpu_addr[27:26]);
    endproperty
    a_row8k: assert property (p_row8k) else $error("8k row or bank misplaced");

    // two taken requests in a row that differ only above the bank field
    sequence s_alias_pair;
        (req_valid && cfg.width == SAM_BUS16 && cfg.rows == SAM_ROWS2K && cfg.cols == SAM_COLS256)
            ##1 (req_valid && $stable(cfg) && cpu_addr[21:0] == $past(cpu_addr[21:0]));
    endsequence

    property p_top_ignored;
        @(posedge mclk) disable iff (!rst_n)
        s_alias_pair |=> $stable(map_ff);
    endproperty
    a_top_ignored: assert property (p_top_ignored) else $error("bits above bank changed map");

    property p_valid;
        @(posedge mclk) disable iff (!rst_n)
        req_valid |=> map_valid_ff;
    endproperty
    a_valid: assert property (p_valid) else $error("mapping not presented");

    property p_idle;
        @(posedge mclk) disable iff (!rst_n)
        !req_valid |=> !map_valid_ff;
    endproperty
    a_idle: assert property (p_idle) else $error("mapping presented without request");
endmodule

/* File: sam_sdram_model.sv */
// sdram side of the mapper: latches every mapped address it is handed
// assumes the mapper's registered outputs and one clock domain
`timescale 1ns/1ps
module sam_sdram_model
    import sam_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic map_valid,
    input wire sam_map_t map,
    input wire logic [1:0] ba,
    output logic [15:0] seen_cnt_ff,
    output sam_map_t last_map_ff,
    output logic [1:0] last_ba_ff
);
    // count and keep each bank/row/column select the device receives
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seen_cnt_ff <= 16'h0000;
            last_map_ff <= '0;
            last_ba_ff <= 2'h0;
        end else if (map_valid) begin
            seen_cnt_ff <= seen_cnt_ff + 16'h0001;
            last_map_ff <= map;
            last_ba_ff <= ba;
        end
    end
endmodule

/* File: sam_mapper_bench.sv */
// self-checking bench of the sdram address mapper
// assumes the mapper answers one cycle after each taken request
`timescale 1ns/1ps
module sam_mapper_bench
    import sam_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    sam_cfg_t cfg = '{width: SAM_BUS32, rows: SAM_ROWS2K, cols: SAM_COLS256};
    logic req_valid = 1'b0;
    logic [27:0] cpu_addr = 28'h0000000;
    logic map_valid_ff;
    sam_map_t map_ff;
    logic [1:0] ba_ff;
    logic halfword_byte_offset_ff;
    logic [15:0] seen_cnt;
    sam_map_t last_map;
    logic [1:0] last_ba;
    int checks = 0;
    int miscompares = 0;
    int sent = 0;

    sam_mapper u_dut (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .req_valid(req_valid),
        .cpu_addr(cpu_addr), .map_valid_ff(map_valid_ff), .map_ff(map_ff), .ba_ff(ba_ff),
        .halfword_byte_offset_ff(halfword_byte_offset_ff));
    sam_sdram_model u_mem (.mclk(mclk), .rst_n(rst_n), .map_valid(map_valid_ff),
        .map(map_ff), .ba(ba_ff), .seen_cnt_ff(seen_cnt), .last_map_ff(last_map),
        .last_ba_ff(last_ba));

    // 200 mhz clock
    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // expected split worked out from the field layout
    function automatic sam_map_t exp_map(sam_cfg_t c, logic [27:0] a);
        int ow;
        int cw;
        int rw;
        logic [27:0] s;
        sam_map_t m;
        ow = (c.width == SAM_BUS16) ? 1 : 2;
        cw = 8 + int'(c.cols);
        rw = (c.rows == SAM_ROWS4K) ? 12 : (c.rows == SAM_ROWS8K) ? 13 : 11;
        m = '0;
        m.byte_ofs = (ow == 1) ? {1'b0, a[0]} : a[1:0];
        s = a >> ow;
        m.col = 11'(s & ((28'h1 << cw) - 28'h1));
        s = s >> cw;
        m.row = 13'(s & ((28'h1 << rw) - 28'h1));
        s = s >> rw;
        m.bank_field = s[1:0];
        return m;
    endfunction

    task automatic check_map(sam_map_t got, sam_map_t exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected map at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_bits(logic [1:0] got, logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected bits at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // checks all outputs against the expected split of one address
    task automatic check_all(sam_cfg_t c, logic [27:0] a, logic v);
        sam_map_t e;
        e = exp_map(c, a);
        check_bits({1'b0, map_valid_ff}, {1'b0, v});
        check_map(map_ff, e);
        check_bits(ba_ff, e.bank_field);
        check_bits({1'b0, halfword_byte_offset_ff}, {1'b0, c.width == SAM_BUS16 & a[0]});
    endtask

    task automatic t_reset();
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        check_map(map_ff, '0);
        check_bits({map_valid_ff, halfword_byte_offset_ff}, 2'h0);
        check_bits(ba_ff, 2'h0);
        $display("test reset done");
    endtask

    // every geometry incl. reserved codes, two patterns, upper bits set, result holds
    task automatic t_sweep();
        logic [27:0] pats [2] = '{28'h5a3c96f, 28'ha5c3690};
        sam_cfg_t c;
        for (int w = 0; w < 4; w++) begin
            for (int r = 0; r < 4; r++) begin
                for (int k = 0; k < 4; k++) begin
                    c = '{width: sam_width_t'(w), rows: sam_rows_t'(r),
                        cols: sam_cols_t'(k)};
                    @(posedge mclk);
                    cfg <= c;
                    foreach (pats[i]) begin
                        @(posedge mclk);
                        req_valid <= 1'b1;
                        cpu_addr <= pats[i];
                        @(posedge mclk);
                        req_valid <= 1'b0;
                        cpu_addr <= ~pats[i];
                        sent++;
                        #1;
                        check_all(c, pats[i], 1'b1);
                        @(posedge mclk);
                        #1;
                        check_all(c, pats[i], 1'b0);
                    end
                end
            end
        end
        $display("test sweep done");
    endtask

    // same low bits twice in a row, top bits flipped: the mapping must not move
    task automatic t_alias();
        sam_cfg_t c;
        logic [27:0] a;
        c = '{width: SAM_BUS16, rows: SAM_ROWS2K, cols: SAM_COLS256};
        a = 28'h2b7d3e1;
        @(posedge mclk);
        cfg <= c;
        @(posedge mclk);
        req_valid <= 1'b1;
        cpu_addr <= a;
        @(posedge mclk);
        cpu_addr <= a ^ 28'hfc00000;
        #1;
        check_all(c, a, 1'b1);
        @(posedge mclk);
        req_valid <= 1'b0;
        sent += 2;
        #1;
        check_all(c, a ^ 28'hfc00000, 1'b1);
        check_map(map_ff, exp_map(c, a));
        @(posedge mclk);
        #1;
        check_all(c, a, 1'b0);
        $display("test alias done");
    endtask

    // requests on every cycle, each answer one cycle later
    task automatic t_back2back();
        sam_cfg_t c;
        logic [27:0] a [8];
        sam_map_t e;
        c = '{width: SAM_BUS16, rows: SAM_ROWS8K, cols: SAM_COLS2K};
        @(posedge mclk);
        cfg <= c;
        for (int i = 0; i < 8; i++) begin
            a[i] = 28'(28'h1234567 * (i + 1) ^ 28'hfedcba9);
        end
        for (int i = 0; i <= 8; i++) begin
            @(posedge mclk);
            req_valid <= (i < 8);
            cpu_addr <= (i < 8) ? a[i % 8] : 28'h0000000;
            #1;
            if (i > 0) begin
                check_all(c, a[i - 1], 1'b1);
                sent++;
            end
        end
        @(posedge mclk);
        #1;
        e = exp_map(c, a[7]);
        check_map(last_map, e);
        check_bits(last_ba, e.bank_field);
        check_bits(seen_cnt[1:0], sent[1:0]);
        check_bits({1'b0, seen_cnt == 16'(sent)}, 2'h1);
        $display("test back to back done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        t_reset();
        t_sweep();
        t_alias();
        t_back2back();
        tally_and_finish();
    end

    // watchdog: the run needs about 500 cycles
    initial begin
        #20000;
        miscompares++;
        tally_and_finish();
    end
endmodule
